// ==== pkg/bss_pkg.sv ====
// constants and types for bus status and reset strap sampling
package bss_pkg;
   // cycle status codes, three bits, active-low pins
   localparam logic [2:0] CYC_INTA     = 3'h0;
   localparam logic [2:0] CYC_IO_RD    = 3'h1;
   localparam logic [2:0] CYC_IO_WR    = 3'h2;
   localparam logic [2:0] CYC_HALT     = 3'h3;
   localparam logic [2:0] CYC_FETCH    = 3'h4;
   localparam logic [2:0] CYC_MEM_RD   = 3'h5;
   localparam logic [2:0] CYC_MEM_WR   = 3'h6;
   localparam logic [2:0] CYC_PASSIVE  = 3'h7;
   // clock mode encodings {sel2, sel1}
   localparam logic [1:0] CLK_X4       = 2'h3;
   localparam logic [1:0] CLK_DIV2     = 2'h2;
   localparam logic [1:0] CLK_X1       = 2'h1;
   localparam logic [1:0] CLK_RSVD     = 2'h0;
   // upper chip select reset window, 20-bit addresses
   localparam logic [19:0] UCS_BASE_RST = 20'hF0000;
   localparam logic [19:0] UCS_MASK_RST = 20'hF0000;
   localparam logic [19:0] BOOT_ADDR    = 20'hFFFF0;
   // strap valid delay after the strap latching edge, in clock cycles
   localparam int          STRAP_DLY    = 2;
   // bus cycle phases t1..t4, gray coded
   typedef enum logic [2:0] {
      PH_IDLE = 3'h0,
      PH_T1   = 3'h1,
      PH_T2   = 3'h3,
      PH_T3   = 3'h2,
      PH_T4   = 3'h6
   } bss_phase_t;
endpackage

// ==== src/bss_strap_latch.sv ====
// latches reset straps once after reset release and holds them
`timescale 1ns/1ps
module bss_strap_latch #(
   parameter int W = 6
) (
   input  wire logic         ref_clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] strap_in,
   output logic      [W-1:0] strap_out,
   output logic              strap_valid
);
   import bss_pkg::*;
   logic [1:0] cnt_reg;
   // counter starts at release; straps caught by clock, not by reset
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg     <= 2'h0;
         strap_valid <= 1'b0;
      end else if (!strap_valid) begin
         cnt_reg <= cnt_reg + 2'h1;
         if (cnt_reg == 2'(STRAP_DLY)) begin
            strap_valid <= 1'b1; // [R8]
         end
      end
   end
   // held until the next reset, later pin changes ignored
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_out <= {W{1'b1}};
      end else if (!strap_valid && cnt_reg == 2'h0) begin
         strap_out <= strap_in; // [R21] [R12]
      end
   end
endmodule

// ==== src/bss_top.sv ====
// bus cycle status outputs and reset strap mode selection
`timescale 1ns/1ps
// Function
// R1 - drive active-low cycle status code for the current cycle type
// R2 - float status in hold, hold ack and float-all; pullup in reset
// R3 - dma flag high in t2..t4 of dma cycles; floated in hold or reset
// R4 - internal memory disable strap turns internal memory off
// R5 - show-read strap drives internal reads, both bytes, onto ad bus
// R6 - clock mode from two straps: x4, div2, x1, reserved
// R7 - div2 mode halves input clock and keeps pll off
// R8 - clock straps latched within three cycles after reset rises
// R9 - system holds clock straps stable four cycles before release; the bench's first reset holds them two cycles
// R10 - system never presents both clock selects low
// R11 - gpio driver on clock select one never pulls low in reset
// R12 - both float-all requests low at release floats every pin
// R13 - upper select defaults to f0000..fffff so boot fetch hits
// R14 - upper select for programmable block up to 512k; high in hold
// R15 - vector indicator is and of inverted top four address bits
// R16 - vector indicator only in t1; floated in hold and float-all
// R17 - sync ready active high, sampled on bus clock, no extra sync
// R18 - sync ready forced low when its pin is a gpio
// R19 - unused sync ready tied low by the system
// R20 - high byte write is or of byte-high and write; pullup, float
// R21 - strap modes held until next reset
// R22 - status passive when idle and at end of each cycle
module bss_top
   import bss_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        hold_active,
   input  wire logic        cycle_start,
   input  wire logic [2:0]  cycle_type,
   input  wire logic        cycle_dma,
   input  wire logic [19:0] cycle_addr,
   input  wire logic        byte_high_enable_n,
   input  wire logic        write_strobe_n,
   input  wire logic        async_ready_in,
   input  wire logic        sync_ready_in,
   input  wire logic        sync_ready_is_gpio,
   input  wire logic [19:0] ucs_base,
   input  wire logic [19:0] ucs_mask,
   input  wire logic        ucs_cfg_load,
   input  wire logic        int_read_valid,
   input  wire logic [15:0] int_read_data,
   input  wire logic        internal_memory_off_strap,
   input  wire logic        show_internal_reads_strap,
   input  wire logic        clock_select_strap_one,
   input  wire logic        clock_select_strap_two,
   input  wire logic        float_all_request_zero,
   input  wire logic        float_all_request_one,
   output logic [2:0]       cycle_status_n,
   output logic [2:0]       cycle_status_oe_n,
   output logic             dma_cycle_flag,
   output logic             dma_cycle_flag_oe_n,
   output logic             upper_memory_select_n,
   output logic             upper_memory_select_oe_n,
   output logic             vector_table_indicator_n,
   output logic             vector_table_indicator_oe_n,
   output logic             write_high_byte_n,
   output logic             write_high_byte_oe_n,
   output logic [15:0]      muxed_addr_data_bus,
   output logic             muxed_addr_data_bus_oe_n,
   output logic             cycle_ready,
   output logic             internal_memory_off,
   output logic             clock_mode_div2,
   output logic             clock_mode_x1,
   output logic             pll_enable,
   output logic             clock_half_en,
   output logic             float_all_mode,
   output logic             straps_valid
);
   ////////////////////////////////////////////////////////////////////
   logic [5:0]  straps;
   logic        sv;
   bss_phase_t  phase_reg;
   bss_phase_t  phase_next;
   logic [2:0]  type_reg;
   logic        dma_reg;
   logic [19:0] addr_reg;
   logic [19:0] base_reg;
   logic [19:0] mask_reg;
   logic        float_w;
   logic        hiz_w;
   logic        sync_ready_in_w;

   // only memory cycles may select the upper block, never i/o or halt
   function automatic logic ucs_hit(input logic [2:0]  t,
                                    input logic [19:0] a,
                                    input logic [19:0] b,
                                    input logic [19:0] m);
      ucs_hit = (t >= CYC_FETCH) && (t != CYC_PASSIVE) &&
                ((a & m) == (b & m));
   endfunction

   bss_strap_latch #(.W(6)) u_strap (
      .ref_clk     (ref_clk),
      .reset_n     (reset_n),
      .strap_in    ({internal_memory_off_strap, show_internal_reads_strap,
                     clock_select_strap_two, clock_select_strap_one,
                     float_all_request_one, float_all_request_zero}),
      .strap_out   (straps),
      .strap_valid (sv)
   );

   assign float_w = (straps[1:0] == 2'h0); // [R12]
   assign hiz_w   = float_w | hold_active; // [R2]
   // a gpio-configured ready pin must never complete a cycle
   assign sync_ready_in_w  = sync_ready_in & ~sync_ready_is_gpio; // [R18] [R17]

   ////////////////////////////////////////////////////////////////////
   // strap-derived modes, all registered
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         internal_memory_off <= 1'b0;
         clock_mode_div2     <= 1'b0;
         clock_mode_x1       <= 1'b0;
         pll_enable          <= 1'b1;
         float_all_mode      <= 1'b0;
         straps_valid        <= 1'b0;
      end else begin
         straps_valid        <= sv;
         internal_memory_off <= sv & ~straps[5]; // [R4]
         clock_mode_div2     <= sv & (straps[3:2] == CLK_DIV2); // [R6]
         clock_mode_x1       <= sv & (straps[3:2] == CLK_X1); // [R6]
         pll_enable          <= ~(sv & (straps[3:2] == CLK_DIV2)); // [R7]
         float_all_mode      <= sv & float_w; // [R12]
      end
   end

   // divide-by-two enable; only meaningful in div2 mode
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         clock_half_en <= 1'b0;
      end else if (clock_mode_div2) begin
         clock_half_en <= ~clock_half_en; // [R7]
      end else begin
         clock_half_en <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bus cycle phase sequencer t1..t4
   always_comb begin
      case (phase_reg)
         PH_IDLE: phase_next = cycle_start ? PH_T1 : PH_IDLE;
         PH_T1:   phase_next = PH_T2;
         PH_T2:   phase_next = PH_T3;
         PH_T3:   phase_next = cycle_ready ? PH_T4 : PH_T3;
         PH_T4:   phase_next = cycle_start ? PH_T1 : PH_IDLE;
         default: phase_next = PH_IDLE;
      endcase
      // refused starts must not leak onto status, ucs or uzi either
      if (!sv || hold_active) begin
         phase_next = PH_IDLE;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_reg <= PH_IDLE;
      end else if (!sv || hold_active) begin
         phase_reg <= PH_IDLE;
      end else begin
         phase_reg <= phase_next;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         type_reg <= CYC_PASSIVE;
         dma_reg  <= 1'b0;
         addr_reg <= BOOT_ADDR;
      end else if (phase_next == PH_T1 && sv && !hold_active) begin
         type_reg <= cycle_type;
         dma_reg  <= cycle_dma;
         addr_reg <= cycle_addr;
      end
   end

   // sync ready used directly; async path assumed already synchronised
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cycle_ready <= 1'b0;
      end else begin
         cycle_ready <= sync_ready_in_w | async_ready_in; // [R17]
      end
   end

   // upper window reloads only on request; reset gives boot window
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         base_reg <= UCS_BASE_RST; // [R13]
         mask_reg <= UCS_MASK_RST; // [R13]
      end else if (ucs_cfg_load && ucs_mask[19]) begin
         base_reg <= ucs_base; // [R14]
         mask_reg <= ucs_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin drivers; oe_n low means driving
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cycle_status_n    <= CYC_PASSIVE; // [R2]
         cycle_status_oe_n <= 3'h7;
      end else begin
         cycle_status_oe_n <= {3{hiz_w}}; // [R2]
         if (phase_next == PH_T1 || phase_next == PH_T2) begin
            cycle_status_n <= (phase_next == PH_T1) ? cycle_type
                                                    : type_reg; // [R1]
         end else begin
            cycle_status_n <= CYC_PASSIVE; // [R22]
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         dma_cycle_flag      <= 1'b0;
         dma_cycle_flag_oe_n <= 1'b1; // [R3]
      end else begin
         dma_cycle_flag_oe_n <= hold_active | float_w; // [R3]
         dma_cycle_flag <= dma_reg & (phase_next == PH_T2 ||
                           phase_next == PH_T3 || phase_next == PH_T4); // [R3]
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         upper_memory_select_n    <= 1'b1;
         upper_memory_select_oe_n <= 1'b0;
      end else begin
         upper_memory_select_oe_n <= float_w;
         if (hold_active || phase_next == PH_IDLE) begin
            upper_memory_select_n <= 1'b1; // [R14]
         end else if (phase_next == PH_T1) begin
            upper_memory_select_n <=
               ~ucs_hit(cycle_type, cycle_addr, base_reg, mask_reg); // [R14]
         end else begin
            upper_memory_select_n <=
               ~ucs_hit(type_reg, addr_reg, base_reg, mask_reg);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         vector_table_indicator_n    <= 1'b1;
         vector_table_indicator_oe_n <= 1'b1;
      end else begin
         vector_table_indicator_oe_n <= hiz_w; // [R16]
         if (phase_next == PH_T1) begin
            vector_table_indicator_n <= |cycle_addr[19:16]; // [R15] [R16]
         end else begin
            vector_table_indicator_n <= 1'b1; // [R16]
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         write_high_byte_n    <= 1'b1; // [R20]
         write_high_byte_oe_n <= 1'b1;
      end else begin
         write_high_byte_oe_n <= hiz_w; // [R20]
         write_high_byte_n <= byte_high_enable_n | write_strobe_n; // [R20]
      end
   end

   // show-read: whole word driven, unused byte included
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         muxed_addr_data_bus      <= 16'h0000;
         muxed_addr_data_bus_oe_n <= 1'b1;
      end else begin
         muxed_addr_data_bus_oe_n <=
            ~(sv & ~straps[4] & int_read_valid & ~hiz_w); // [R5]
         muxed_addr_data_bus      <= int_read_data; // [R5]
      end
   end

   ////////////////////////////////////////////////////////////////////
   a_status_passive: assert property ( // [R22]
      @(posedge ref_clk) disable iff (!reset_n)
      phase_reg == PH_IDLE && (!cycle_start || hold_active)
      |=> cycle_status_n == CYC_PASSIVE)
      else $error("status not passive while idle");
   a_dma_window: assert property ( // [R3]
      @(posedge ref_clk) disable iff (!reset_n)
      dma_cycle_flag |-> phase_reg != PH_T1 && phase_reg != PH_IDLE)
      else $error("dma flag outside t2..t4");
   a_vector_t1: assert property ( // [R15] [R16]
      @(posedge ref_clk) disable iff (!reset_n)
      !vector_table_indicator_n |-> phase_reg == PH_T1 &&
      $past(cycle_addr[19:16]) == 4'h0)
      else $error("vector indicator wrong");
   a_whb_or: assert property ( // [R20]
      @(posedge ref_clk) disable iff (!reset_n)
      write_high_byte_n == ($past(byte_high_enable_n) |
      $past(write_strobe_n)))
      else $error("high byte write not or");
   a_float_hiz: assert property ( // [R12] [R2]
      @(posedge ref_clk) disable iff (!reset_n)
      float_all_mode |-> cycle_status_oe_n == 3'h7 &&
      vector_table_indicator_oe_n && dma_cycle_flag_oe_n &&
      upper_memory_select_oe_n && write_high_byte_oe_n &&
      muxed_addr_data_bus_oe_n)
      else $error("float-all pins driven");
   a_ucs_hold: assert property ( // [R14]
      @(posedge ref_clk) disable iff (!reset_n)
      hold_active |=> upper_memory_select_n)
      else $error("upper select low in hold");
   a_strap_time: assert property ( // [R8]
      @(posedge ref_clk) disable iff (!reset_n)
      $rose(reset_n) || !sv |-> ##[0:3] sv)
      else $error("straps not latched in time");
   a_strap_hold: assert property ( // [R21]
      @(posedge ref_clk) disable iff (!reset_n)
      sv && $past(sv) |-> $stable(straps))
      else $error("strap changed after latch");
   a_pll_div2: assert property ( // [R7]
      @(posedge ref_clk) disable iff (!reset_n)
      clock_mode_div2 |-> !pll_enable)
      else $error("pll on in div2");
   a_sync_ready_in_gpio: assert property ( // [R18]
      @(posedge ref_clk) disable iff (!reset_n)
      sync_ready_is_gpio && !async_ready_in |=> !cycle_ready)
      else $error("gpio ready leaked");
endmodule

// ==== tb/bss_sys_model.sv ====
// system-side model: answers each bus cycle with ready after some waits
`timescale 1ns/1ps
module bss_sys_model
   import bss_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic [2:0] cycle_status_n,
   input  wire logic [2:0] cycle_status_oe_n,
   input  wire logic       cycle_ready,
   input  wire logic       use_sync,
   input  wire logic [3:0] wait_cycles,
   output logic            sync_ready_in,
   output logic            async_ready_in
);
   logic [2:0] last_reg;
   logic [3:0] cnt_reg;
   logic       armed_reg;
   logic       rdy_reg;
   ////////////////////////////////////////////////////////////////////////
   // data phase starts when a driven status drops back to passive
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         last_reg  <= CYC_PASSIVE;
         cnt_reg   <= 4'h0;
         armed_reg <= 1'b0;
         rdy_reg   <= 1'b0;
      end else begin
         last_reg <= cycle_status_n;
         if (cycle_status_oe_n == 3'h0 && last_reg != CYC_PASSIVE &&
             cycle_status_n == CYC_PASSIVE) begin
            armed_reg <= 1'b1;
            cnt_reg   <= wait_cycles;
         end else if (armed_reg) begin
            cnt_reg   <= cnt_reg - 4'h1;
            armed_reg <= cnt_reg != 4'h0;
            rdy_reg   <= cnt_reg == 4'h0;
         end else if (rdy_reg && cycle_ready) begin
            rdy_reg <= 1'b0; // held until completion, slow devices too
         end
      end
   end
   // the unused ready line stays low so the other path decides
   assign sync_ready_in  = rdy_reg & use_sync;
   assign async_ready_in = rdy_reg & ~use_sync;
endmodule

// ==== tb/tb.sv ====
// self-checking bench for bus status and reset strap selection
`timescale 1ns/1ps
module tb;
   import bss_pkg::*;
   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        hold_active, cycle_start, cycle_dma, ucs_cfg_load;
   logic [2:0]  cycle_type, cycle_status_n, cycle_status_oe_n;
   logic [19:0] cycle_addr, ucs_base, ucs_mask, ub, um, a;
   logic        byte_high_enable_n, write_strobe_n, async_ready_in;
   logic        sync_ready_in, sync_ready_is_gpio, int_read_valid;
   logic [15:0] int_read_data, muxed_addr_data_bus;
   logic        internal_memory_off_strap, show_internal_reads_strap;
   logic        clock_select_strap_one, clock_select_strap_two;
   logic        float_all_request_zero, float_all_request_one;
   logic        dma_cycle_flag, dma_cycle_flag_oe_n, upper_memory_select_n;
   logic        upper_memory_select_oe_n, vector_table_indicator_n;
   logic        vector_table_indicator_oe_n, write_high_byte_n;
   logic        write_high_byte_oe_n, muxed_addr_data_bus_oe_n, cycle_ready;
   logic        internal_memory_off, clock_mode_div2, clock_mode_x1;
   logic        pll_enable, clock_half_en, float_all_mode, straps_valid;
   logic        use_sync;
   logic [3:0]  wait_cycles;
   logic [5:0]  v;
   int          errors = 0;
   int          checked = 0;
   int          k;

   bss_top dut_u (.*);
   bss_sys_model sys_u (.*);

   always #2 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic tick(int n = 1);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic chk(string what, logic [19:0] seen, logic [19:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   function automatic logic exp_ucs_n(logic [19:0] x);
      return (x & um) != (ub & um);
   endfunction

   task automatic set_straps(logic [5:0] x);
      {float_all_request_one, float_all_request_zero, clock_select_strap_two,
       clock_select_strap_one, show_internal_reads_strap,
       internal_memory_off_strap} = x;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic do_reset(logic [5:0] x, int n);
      int i;
      reset_n = 1'b0;
      set_straps(x);
      tick(n);
      chk("status rst", cycle_status_n, CYC_PASSIVE);
      chk("status oe rst", cycle_status_oe_n, 3'h7);
      chk("dma oe rst", dma_cycle_flag_oe_n, 1'b1);
      chk("whb oe rst", write_high_byte_oe_n, 1'b1);
      reset_n = 1'b1;
      ub = UCS_BASE_RST;
      um = UCS_MASK_RST;
      i = 0;
      while (straps_valid !== 1'b1 && i < 20) begin
         tick();
         i++;
      end
      // straps caught at edge one; the valid flag shows one stage later
      chk("strap latch", 20'(i), 20'(STRAP_DLY + 2));
      tick();
      set_straps(x ^ 6'h33); // clock selects left alone
   endtask

   task automatic chk_modes(logic [5:0] x);
      logic h;
      chk("float all", float_all_mode, x[5:4] == 2'h0);
      chk("imem off", internal_memory_off, !x[0]);
      chk("div2", clock_mode_div2, x[3:2] == CLK_DIV2);
      chk("x1", clock_mode_x1, x[3:2] == CLK_X1);
      if (x[3:2] != CLK_X1)
         chk("pll", pll_enable, x[3:2] == CLK_X4);
      h = clock_half_en;
      tick();
      chk("half en", clock_half_en, x[3:2] == CLK_DIV2 ? !h : 1'b1);
      chk("held imem", internal_memory_off, !x[0]);
   endtask

   task automatic run_cycle(logic [2:0] t, logic d, logic [19:0] x, logic g);
      int i;
      cycle_type = t;
      cycle_dma = d;
      cycle_addr = x;
      cycle_start = 1'b1;
      tick();
      cycle_start = 1'b0;
      chk("status t1", cycle_status_n, t);
      chk("uzi t1", vector_table_indicator_n, x[19:16] != 4'h0);
      if (t >= CYC_FETCH)
         chk("ucs t1", upper_memory_select_n, exp_ucs_n(x));
      else
         chk("ucs io t1", upper_memory_select_n, 1'b1);
      tick();
      chk("status t2", cycle_status_n, t);
      chk("uzi t2", vector_table_indicator_n, 1'b1);
      chk("dma t2", dma_cycle_flag, d);
      tick();
      chk("status t3", cycle_status_n, CYC_PASSIVE);
      chk("dma t3", dma_cycle_flag, d);
      for (i = 0; g && i < 8; i++) begin
         chk("gpio ready", cycle_ready, 1'b0);
         tick();
      end
      sync_ready_is_gpio = 1'b0;
      i = 0;
      while (cycle_ready !== 1'b1 && i < 40) begin
         tick();
         i++;
      end
      chk("ready seen", cycle_ready, 1'b1);
      tick(3);
      chk("status idle", cycle_status_n, CYC_PASSIVE);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {hold_active, cycle_start, cycle_dma, ucs_cfg_load} = 4'h0;
      {cycle_type, cycle_addr, ucs_base, ucs_mask} = '0;
      {int_read_valid, int_read_data, sync_ready_is_gpio} = '0;
      {byte_high_enable_n, write_strobe_n} = 2'h3;
      use_sync = 1'b0;
      wait_cycles = 4'h0;
      set_straps(6'h3F);
      void'($urandom(32'hDAD3C432));
      do_reset(6'h3F, 2);
      chk_modes(6'h3F);
      $display("test reset done");
      for (k = 0; k < 7; k++) begin
         v = 6'($urandom());
         v[3:2] = k % 3 == 0 ? CLK_X4 : k % 3 == 1 ? CLK_DIV2 : CLK_X1;
         v[5:4] = k == 6 ? 2'h0 : v[5:4] | 2'h1;
         do_reset(v, 5);
         chk_modes(v);
         if (v[5:4] == 2'h0) begin
            chk("float st oe", cycle_status_oe_n, 3'h7);
            chk("float uzi oe", vector_table_indicator_oe_n, 1'b1);
            chk("float whb oe", write_high_byte_oe_n, 1'b1);
            chk("float bus oe", muxed_addr_data_bus_oe_n, 1'b1);
            chk("float ucs oe", upper_memory_select_oe_n, 1'b1);
         end else if (!v[1] && v[0]) begin
            int_read_data = 16'($urandom());
            int_read_valid = 1'b1;
            tick();
            int_read_valid = 1'b0;
            chk("show data", muxed_addr_data_bus, int_read_data);
            chk("show oe", muxed_addr_data_bus_oe_n, 1'b0);
         end
         $display("test strap %0d done", k);
      end
      do_reset(6'h3F, 5);
      run_cycle(CYC_FETCH, 1'b0, BOOT_ADDR, 1'b0);
      for (k = 0; k < 14; k++) begin
         a = 20'($urandom());
         if (k < 3)
            a[19:16] = 4'h0;
         use_sync = 1'($urandom());
         wait_cycles = 4'($urandom_range(3));
         run_cycle(3'(k % 7), 1'($urandom()), a, 1'b0);
      end
      ucs_base = 20'h80000;
      ucs_mask = 20'h80000;
      ucs_cfg_load = 1'b1;
      tick();
      ucs_cfg_load = 1'b0;
      ub = ucs_base;
      um = ucs_mask;
      run_cycle(CYC_MEM_RD, 1'b0, 20'h8ABCD, 1'b0);
      run_cycle(CYC_MEM_WR, 1'b1, 20'h71234, 1'b0);
      $display("test cycles done");
      hold_active = 1'b1;
      tick(2);
      chk("hold st oe", cycle_status_oe_n, 3'h7);
      chk("hold dma oe", dma_cycle_flag_oe_n, 1'b1);
      chk("hold ucs", upper_memory_select_n, 1'b1);
      chk("hold uzi oe", vector_table_indicator_oe_n, 1'b1);
      chk("hold whb oe", write_high_byte_oe_n, 1'b1);
      cycle_start = 1'b1;
      tick();
      {cycle_start, hold_active} = 2'h0;
      tick(2);
      chk("no cycle", cycle_status_n, CYC_PASSIVE);
      $display("test hold done");
      use_sync = 1'b1;
      sync_ready_is_gpio = 1'b1;
      run_cycle(CYC_IO_RD, 1'b0, 20'h00100, 1'b1);
      $display("test gpio ready done");
      for (k = 0; k < 4; k++) begin
         {byte_high_enable_n, write_strobe_n} = 2'(k);
         tick(2);
         chk("whb", write_high_byte_n, k != 0);
         chk("whb oe", write_high_byte_oe_n, 1'b0);
      end
      $display("test write byte done");
      test_done();
   end

   // a hang is cut short well beyond the few hundred cycles needed
   initial begin
      tick(30000);
      errors++;
      test_done();
   end
endmodule
